// [core/diag_alarm_pkg.sv]
// Constants for the diagnostic flag register and the dual alarm monitor.
package diag_alarm_pkg;
	// Register indices on the internal register port.
	localparam logic [3:0] IDX_DIAG_FLAGS = 4'h0;
	localparam logic [3:0] IDX_ALM1_THR = 4'h1;
	localparam logic [3:0] IDX_ALM2_THR = 4'h2;
	localparam logic [3:0] IDX_ALM1_CNT = 4'h3;
	localparam logic [3:0] IDX_ALM2_CNT = 4'h4;
	localparam logic [3:0] IDX_ALARM_CONTROL = 4'h5;
	// Reset values.
	localparam logic [15:0] RST_DIAG_FLAGS = 16'h0000;
	localparam logic [15:0] RST_ALM_THR = 16'h0000;
	localparam logic [15:0] RST_ALM_CNT = 16'h0000;
	localparam logic [15:0] RST_ALARM_CONTROL = 16'h0000;
	// Diagnostic flag positions.
	localparam int FLG_ACC_ST_HI = 15;
	localparam int FLG_GYR_ST_LO = 10;
	localparam int FLG_ALM2 = 9;
	localparam int FLG_ALM1 = 8;
	localparam int FLG_UNUSED = 7;
	localparam int FLG_FLASH_CHK = 6;
	localparam int FLG_ST_DIAG = 5;
	localparam int FLG_OVERRANGE = 4;
	localparam int FLG_SERIAL = 3;
	localparam int FLG_FLASH_UPD = 2;
	localparam int FLG_SUPPLY_HI = 1;
	localparam int FLG_SUPPLY_LO = 0;
	// Threshold fields.
	localparam int THR_DIR = 15;
	localparam int THR_W = 14;
	// Sample count field width and history depth.
	localparam int CNT_W = 8;
	localparam int HIST_DEPTH = 256;
	// Alarm control fields.
	localparam int CTL_SRC2_LO = 12;
	localparam int CTL_SRC1_LO = 8;
	localparam int CTL_RATE2 = 7;
	localparam int CTL_RATE1 = 6;
	localparam int CTL_FILT = 4;
	localparam int CTL_OUT_EN = 2;
	localparam int CTL_OUT_POL = 1;
	localparam int CTL_OUT_SEL = 0;
	// Source codes: 0 disables, 1..11 select a source word.
	localparam logic [3:0] SRC_DISABLE = 4'h0;
	localparam logic [3:0] SRC_LAST = 4'hB;
	localparam int NUM_SRC = 11;
	localparam int SRC_WORD_W = 16;
endpackage

// [core/diag_alarm_monitor.sv]
// Diagnostic flag register with read-to-clear flags and two independent alarms.
//
// Operation
// - Reading the flag register clears every error flag except the two supply flags.
// - A persisting error condition sets its flag again at the next sample cycle.
// - Supply flags bits 1:0 ignore reads and clear when supply returns in range.
// - Bits 15:13 accel Z/Y/X, bits 12:10 gyro Z/Y/X self-test failures.
// - Bit 9 alarm 2 active, bit 8 alarm 1 active, bit 7 unused.
// - Bit 6 flash checksum, bit 5 self-test diagnostic, bit 4 overrange.
// - Bit 3 serial communication failure, bit 2 flash update failure.
// - Bit 1 supply above 5.25 V, bit 0 supply below 4.75 V.
// - Two alarm channels with their own source, threshold, count and rate settings.
// - Rate period equals sample count times the current sample period.
// - Threshold bit 15 picks greater or less; bits 13:0 hold the threshold.
// - Sample count bits 7:0; values 0x00 and 0x01 both mean one sample.
// - Control bits 15:12 select alarm 2 source; 0000 disables it.
// - Control bits 11:8 select alarm 1 source with the same encoding.
// - Control bits 7 and 6 choose rate-of-change or static comparison.
// - Control bit 4 selects filtered or unfiltered comparison data.
// - Control bits 2:0 set output enable, polarity and line select.
`timescale 1ns/1ps
module diag_alarm_monitor (
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic SAMPLE_TICK_I,
	input wire logic [5:0] ST_FAIL_I,
	input wire logic FLASH_CHK_FAIL_I,
	input wire logic ST_DIAG_ERR_I,
	input wire logic OVERRANGE_I,
	input wire logic SERIAL_FAIL_I,
	input wire logic FLASH_UPD_FAIL_I,
	input wire logic SUPPLY_HIGH_I,
	input wire logic SUPPLY_LOW_I,
	input wire logic [diag_alarm_pkg::NUM_SRC*diag_alarm_pkg::SRC_WORD_W-1:0] SRC_RAW_I,
	input wire logic [diag_alarm_pkg::NUM_SRC*diag_alarm_pkg::SRC_WORD_W-1:0] SRC_FILT_I,
	input wire logic [3:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [15:0] REG_WDATA_I,
	output logic [15:0] REG_RDATA_O,
	output logic [1:0] ALARM_ACTIVE_O,
	output logic DIGITAL_LINE_A_O,
	output logic DIGITAL_LINE_A_OE_N_O,
	output logic DIGITAL_LINE_B_O,
	output logic DIGITAL_LINE_B_OE_N_O
);
	import diag_alarm_pkg::*;

	logic [15:2] err_flags_r;
	logic [1:0] supply_flags_r;
	logic [15:0] diag_flags_r;
	logic [15:0] alarm_thr_r [0:1];
	logic [15:0] alarm_cnt_r [0:1];
	logic [15:0] alarm_control_r;
	logic [15:0] rdata_r;
	logic [1:0] alarm_r;
	logic [1:0] cmp;
	logic [15:0] flag_set;
	logic rd_diag;
	logic alarm_any;
	logic line_level;

	assign rd_diag = REG_RD_I && (REG_ADDR_I == IDX_DIAG_FLAGS);

	// Error sources collected into flag positions; bit 7 never sets.
	always_comb begin
		flag_set = 16'h0000;
		flag_set[FLG_ACC_ST_HI -: 6] = ST_FAIL_I;
		flag_set[FLG_ALM2] = cmp[1];
		flag_set[FLG_ALM1] = cmp[0];
		flag_set[FLG_FLASH_CHK] = FLASH_CHK_FAIL_I;
		flag_set[FLG_ST_DIAG] = ST_DIAG_ERR_I;
		flag_set[FLG_OVERRANGE] = OVERRANGE_I;
		flag_set[FLG_SERIAL] = SERIAL_FAIL_I;
		flag_set[FLG_FLASH_UPD] = FLASH_UPD_FAIL_I;
	end

	// A flag raised in the same cycle as the clearing read survives the read.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			err_flags_r <= RST_DIAG_FLAGS[15:2];
		end else begin
			err_flags_r <= (err_flags_r & ~{14{rd_diag}})
				| (flag_set[15:2] & {14{SAMPLE_TICK_I}});
		end
	end

	// Supply flags follow the comparators each sample and ignore reads.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			supply_flags_r <= RST_DIAG_FLAGS[1:0];
		end else if (SAMPLE_TICK_I) begin
			supply_flags_r[FLG_SUPPLY_HI] <= SUPPLY_HIGH_I;
			supply_flags_r[FLG_SUPPLY_LO] <= SUPPLY_LOW_I;
		end
	end

	// The two halves have separate owners so that each register has a single driver.
	assign diag_flags_r = {err_flags_r, supply_flags_r};

	// Configuration writes.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			alarm_thr_r[0] <= RST_ALM_THR;
			alarm_thr_r[1] <= RST_ALM_THR;
			alarm_cnt_r[0] <= RST_ALM_CNT;
			alarm_cnt_r[1] <= RST_ALM_CNT;
			alarm_control_r <= RST_ALARM_CONTROL;
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				IDX_ALM1_THR: alarm_thr_r[0] <= REG_WDATA_I;
				IDX_ALM2_THR: alarm_thr_r[1] <= REG_WDATA_I;
				IDX_ALM1_CNT: alarm_cnt_r[0] <= REG_WDATA_I;
				IDX_ALM2_CNT: alarm_cnt_r[1] <= REG_WDATA_I;
				IDX_ALARM_CONTROL: alarm_control_r <= REG_WDATA_I;
				default: begin
				end
			endcase
		end
	end

	// Read data is registered; unmapped indices return zero.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_r <= 16'h0000;
		end else if (REG_RD_I) begin
			case (REG_ADDR_I)
				IDX_DIAG_FLAGS: rdata_r <= diag_flags_r;
				IDX_ALM1_THR: rdata_r <= alarm_thr_r[0];
				IDX_ALM2_THR: rdata_r <= alarm_thr_r[1];
				IDX_ALM1_CNT: rdata_r <= alarm_cnt_r[0];
				IDX_ALM2_CNT: rdata_r <= alarm_cnt_r[1];
				IDX_ALARM_CONTROL: rdata_r <= alarm_control_r;
				default: rdata_r <= 16'h0000;
			endcase
		end
	end
	assign REG_RDATA_O = rdata_r;

	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_alarm
			logic [3:0] src_code;
			logic rate_mode;
			logic [CNT_W-1:0] n_eff;
			logic [CNT_W-1:0] wptr_r;
			logic [CNT_W:0] fill_r;
			logic signed [THR_W-1:0] hist [0:HIST_DEPTH-1];
			logic signed [THR_W-1:0] cur;
			logic signed [THR_W-1:0] old;
			logic signed [THR_W:0] value;
			logic signed [THR_W:0] thr;
			logic [CNT_W-1:0] rptr;
			logic hist_ok;
			// Per-channel result bits keep every process the only writer of its variable.
			logic hit;
			logic chan_alarm_r;

			assign src_code = alarm_control_r[(k == 0 ? CTL_SRC1_LO : CTL_SRC2_LO) +: 4];
			assign rate_mode = alarm_control_r[k == 0 ? CTL_RATE1 : CTL_RATE2];
			// Zero and one both give a one-sample period.
			assign n_eff = (alarm_cnt_r[k][CNT_W-1:0] <= 8'h01) ? 8'h01
				: alarm_cnt_r[k][CNT_W-1:0];

			always_comb begin
				int idx;
				idx = 0;
				cur = '0;
				if (src_code != SRC_DISABLE && src_code <= SRC_LAST) begin
					idx = (int'(src_code) - 1) * SRC_WORD_W;
					cur = alarm_control_r[CTL_FILT] ? SRC_FILT_I[idx +: THR_W]
						: SRC_RAW_I[idx +: THR_W];
				end
			end

			// One history slot per sample, so n samples back spans n sample periods.
			assign rptr = wptr_r - n_eff;
			assign old = hist[rptr];
			assign hist_ok = fill_r >= {1'b0, n_eff};
			assign value = rate_mode ? ({cur[THR_W-1], cur} - {old[THR_W-1], old})
				: {cur[THR_W-1], cur};
			assign thr = {alarm_thr_r[k][THR_W-1], alarm_thr_r[k][THR_W-1:0]};

			always_comb begin
				hit = 1'b0;
				if (src_code != SRC_DISABLE && src_code <= SRC_LAST
					&& (!rate_mode || hist_ok)) begin
					hit = alarm_thr_r[k][THR_DIR] ? (value > thr) : (value < thr);
				end
			end
			assign cmp[k] = hit;

			always_ff @(posedge CLK_I) begin
				if (SAMPLE_TICK_I) begin
					hist[wptr_r] <= cur;
				end
			end

			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					wptr_r <= '0;
					fill_r <= '0;
				end else if (SAMPLE_TICK_I) begin
					wptr_r <= wptr_r + 8'h01;
					if (fill_r != HIST_DEPTH[CNT_W:0]) begin
						fill_r <= fill_r + 9'h001;
					end
				end
			end

			always_ff @(posedge CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					chan_alarm_r <= 1'b0;
				end else if (SAMPLE_TICK_I) begin
					chan_alarm_r <= hit;
				end
			end
			assign alarm_r[k] = chan_alarm_r;
		end
	endgenerate

	assign ALARM_ACTIVE_O = alarm_r;
	assign alarm_any = |alarm_r;
	// Active-low polarity drives the line high while no alarm holds.
	assign line_level = alarm_control_r[CTL_OUT_POL] ? alarm_any : ~alarm_any;

	// Lines are released when the indicator is off so another function may use them.
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			DIGITAL_LINE_A_O <= 1'b0;
			DIGITAL_LINE_A_OE_N_O <= 1'b1;
			DIGITAL_LINE_B_O <= 1'b0;
			DIGITAL_LINE_B_OE_N_O <= 1'b1;
		end else begin
			DIGITAL_LINE_A_O <= line_level;
			DIGITAL_LINE_B_O <= line_level;
			DIGITAL_LINE_A_OE_N_O <= !(alarm_control_r[CTL_OUT_EN]
				&& !alarm_control_r[CTL_OUT_SEL]);
			DIGITAL_LINE_B_OE_N_O <= !(alarm_control_r[CTL_OUT_EN]
				&& alarm_control_r[CTL_OUT_SEL]);
		end
	end

	sequence s_clear_read;
		rd_diag && !SAMPLE_TICK_I;
	endsequence

	sequence s_tick_with(logic c);
		SAMPLE_TICK_I && c;
	endsequence

	// A cycle with neither a clearing read nor a sample must leave the flags alone.
	sequence s_quiet;
		!rd_diag && !SAMPLE_TICK_I;
	endsequence

	AST_READ_CLEARS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_clear_read |=> diag_flags_r[15:2] == 14'h0000)
		else $error("error flags not cleared by read");

	AST_REFLAG_NEXT_SAMPLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(OVERRANGE_I) |=> diag_flags_r[FLG_OVERRANGE])
		else $error("persisting overrange did not set its flag");

	AST_SUPPLY_KEEP_ON_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_clear_read |=> diag_flags_r[1:0] == $past(diag_flags_r[1:0]))
		else $error("supply flags changed by a read");

	AST_ACCEL_Z_FLAG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(ST_FAIL_I[5]) |=> diag_flags_r[FLG_ACC_ST_HI])
		else $error("accel Z self-test flag missing");

	AST_UNUSED_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(cmp[1]) |=> diag_flags_r[FLG_ALM2] && !diag_flags_r[FLG_UNUSED])
		else $error("alarm 2 flag or unused bit wrong");

	AST_SUPPLY_TRACK: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		SAMPLE_TICK_I |=> diag_flags_r[1:0] == $past({SUPPLY_HIGH_I, SUPPLY_LOW_I}))
		else $error("supply flags do not follow supply state");

	AST_DISABLED_SILENT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(alarm_control_r[CTL_SRC1_LO +: 4] == SRC_DISABLE) |=> !alarm_r[0])
		else $error("disabled alarm 1 became active");

	AST_LINE_B_LEVEL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		##1 !DIGITAL_LINE_B_OE_N_O |->
		DIGITAL_LINE_B_O == ($past(alarm_control_r[CTL_OUT_POL]) ? $past(alarm_any)
		: !$past(alarm_any)))
		else $error("line B level does not match alarms and polarity");

	AST_LINE_EXCLUSIVE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!(DIGITAL_LINE_A_OE_N_O == 1'b0 && DIGITAL_LINE_B_OE_N_O == 1'b0))
		else $error("both digital lines driven");

	// A set in the clearing cycle wins, so a persisting fault is never lost.
	AST_SET_WINS_ON_READ: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(rd_diag && SERIAL_FAIL_I) |=> diag_flags_r[FLG_SERIAL])
		else $error("flag raised during a clearing read was lost");

	AST_FLAGS_HOLD_IDLE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_quiet |=> $stable(diag_flags_r))
		else $error("flags changed without a read or a sample");

	AST_READ_RETURNS_FLAGS: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		rd_diag |=> REG_RDATA_O == $past(diag_flags_r))
		else $error("flag read did not return the word before clearing");

	AST_GYRO_X_FLAG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(ST_FAIL_I[0]) |=> diag_flags_r[FLG_GYR_ST_LO])
		else $error("gyro X self-test flag missing");

	AST_FLASH_CHK_FLAG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(FLASH_CHK_FAIL_I) |=> diag_flags_r[FLG_FLASH_CHK])
		else $error("flash checksum flag missing");

	AST_FLASH_UPD_FLAG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(FLASH_UPD_FAIL_I) |=> diag_flags_r[FLG_FLASH_UPD])
		else $error("flash update flag missing");

	AST_ALARM1_FLAG: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(cmp[0]) |=> diag_flags_r[FLG_ALM1] && ALARM_ACTIVE_O[0])
		else $error("alarm 1 flag or status missing");

	AST_ALARM_HOLD: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!SAMPLE_TICK_I |=> $stable(ALARM_ACTIVE_O))
		else $error("alarm status changed between samples");

	AST_DISABLED2_SILENT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		s_tick_with(alarm_control_r[CTL_SRC2_LO +: 4] == SRC_DISABLE) |=> !alarm_r[1])
		else $error("disabled alarm 2 became active");

	AST_LINE_A_LEVEL: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		##1 !DIGITAL_LINE_A_OE_N_O |->
		DIGITAL_LINE_A_O == ($past(alarm_control_r[CTL_OUT_POL]) ? $past(alarm_any)
		: !$past(alarm_any)))
		else $error("line A level does not match alarms and polarity");

	AST_OUT_OFF_RELEASED: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		!alarm_control_r[CTL_OUT_EN] |=> DIGITAL_LINE_A_OE_N_O && DIGITAL_LINE_B_OE_N_O)
		else $error("a line is driven while the indicator is disabled");

	AST_THR_WRITE: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
		REG_WR_I && REG_ADDR_I == IDX_ALM1_THR |=> alarm_thr_r[0] == $past(REG_WDATA_I))
		else $error("alarm 1 threshold write did not land");
endmodule

// [testbench/host_model.sv]
// Host processor model that issues register accesses on the internal register port.
`timescale 1ns/1ps
module host_model (
	input wire logic clk_i,
	output logic [3:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] wdata_o
);
	initial begin
		addr_o = 4'hF;
		wdata_o = 16'hFFFF;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Address and data are inverted when idle, so a stale value can never look valid.
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule

// [testbench/diag_status_and_alarm_monitor_tb.sv]
// Self-checking bench for the diagnostic flags and the two alarm channels.
`timescale 1ns/1ps
module diag_status_and_alarm_monitor_tb;
	import diag_alarm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tick = 1'b0;
	logic [5:0] st = '0;
	logic [4:0] err_in = '0;
	logic [1:0] sup = '0;
	logic [175:0] raw = '0;
	logic [175:0] filt = '0;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic wr, rd, rd_seen, la, la_oe_n, lb, lb_oe_n;
	logic [1:0] act;
	int err_total = 0;
	int check_count = 0;
	logic [15:0] exp_q[$];
	int h1[16];
	int h2[16];
	diag_alarm_monitor diag_alarm_monitor_inst (.CLK_I(clk), .RST_N_I(rst_n),
		.SAMPLE_TICK_I(tick), .ST_FAIL_I(st), .FLASH_CHK_FAIL_I(err_in[4]),
		.ST_DIAG_ERR_I(err_in[3]), .OVERRANGE_I(err_in[2]), .SERIAL_FAIL_I(err_in[1]),
		.FLASH_UPD_FAIL_I(err_in[0]), .SUPPLY_HIGH_I(sup[1]), .SUPPLY_LOW_I(sup[0]),
		.SRC_RAW_I(raw), .SRC_FILT_I(filt), .REG_ADDR_I(addr), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ALARM_ACTIVE_O(act),
		.DIGITAL_LINE_A_O(la), .DIGITAL_LINE_A_OE_N_O(la_oe_n),
		.DIGITAL_LINE_B_O(lb), .DIGITAL_LINE_B_OE_N_O(lb_oe_n));
	host_model host_model_inst (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
		.wdata_o(wdata));
	always #5 clk = ~clk;
	always @(posedge clk) rd_seen <= rd;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data is registered on the rising edge that samples the read, so it is taken at the next falling edge.
	always @(negedge clk) if (rd_seen === 1'b1) chk(rdata, exp_q.pop_front());
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host_model_inst.acc(1'b0, a, 16'h0000);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		host_model_inst.acc(1'b1, a, d);
	endtask
	task automatic tk();
		@(negedge clk);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
	endtask
	task automatic rnd_src();
		for (int k = 0; k < NUM_SRC; k++) begin
			raw[k*16+:16] = $urandom;
			filt[k*16+:16] = $urandom;
		end
	endtask
	function automatic int sx(input logic [13:0] v);
		return $signed({{18{v[13]}}, v});
	endfunction
	function automatic int val(input logic [3:0] c, input logic f);
		return f ? sx(filt[(c-1)*16+:14]) : sx(raw[(c-1)*16+:14]);
	endfunction
	function automatic logic cmp(input logic [15:0] thr, input int d);
		return thr[15] ? (d > sx(thr[13:0])) : (d < sx(thr[13:0]));
	endfunction
	function automatic logic on(input logic [3:0] c);
		return (c != SRC_DISABLE) && (c <= SRC_LAST);
	endfunction
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		err_total++;
		stop_test();
	end
	initial begin
		logic [15:0] t1, t2, c;
		logic [1:0] av;
		int n1, n2;
		void'($urandom(71));
		do_reset();
		for (int i = 0; i < 7; i++) rd_reg(i[3:0], 16'h0000);
		// Index 0 is read-only and index 6 is unmapped; both must read back as zero.
		for (int i = 0; i < 7; i++) begin
			c = $urandom;
			wr_reg(i[3:0], c);
			rd_reg(i[3:0], (i == 0 || i == 6) ? 16'h0000 : c);
		end
		wr_reg(IDX_ALARM_CONTROL, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			{st, err_in, sup} = 13'($urandom);
			if (sup == 2'b11) sup = 2'b10;
			tk();
			c = {st, 3'b000, err_in, sup};
			rd_reg(IDX_DIAG_FLAGS, c);
			rd_reg(IDX_DIAG_FLAGS, {14'h0000, sup});
			// A read in the sample cycle returns the cleared word while the sample sets it again.
			fork
				tk();
				rd_reg(IDX_DIAG_FLAGS, {14'h0000, sup});
			join
			rd_reg(IDX_DIAG_FLAGS, c);
			{st, err_in, sup} = '0;
			tk();
			rd_reg(IDX_DIAG_FLAGS, 16'h0000);
		end
		for (int i = 0; i < 16; i++) begin
			rnd_src();
			t1 = $urandom;
			t2 = $urandom;
			c = {4'($urandom), i[3:0], 3'b000, 1'($urandom), 1'b0, 3'($urandom)};
			wr_reg(IDX_ALM1_THR, t1);
			wr_reg(IDX_ALM2_THR, t2);
			wr_reg(IDX_ALARM_CONTROL, c);
			tk();
			av[0] = on(c[11:8]) && cmp(t1, val(c[11:8], c[4]));
			av[1] = on(c[15:12]) && cmp(t2, val(c[15:12], c[4]));
			chk({14'h0000, act}, {14'h0000, av});
			rd_reg(IDX_DIAG_FLAGS, {6'h00, av, 8'h00});
			chk({14'h0000, la_oe_n, lb_oe_n}, c[2] ? {15'h0000, c[0]} + 16'h1 : 16'h3);
			if (c[2]) chk({15'h0000, c[0] ? lb : la}, {15'h0000, c[1] ~^ (av != 2'b00)});
		end
		for (int r = 0; r < 4; r++) begin
			do_reset();
			n1 = $urandom % 6;
			n2 = $urandom % 6;
			t1 = $urandom;
			t2 = $urandom;
			c = {4'(5 + r), 4'(2 + r), 2'b11, 1'b0, 1'($urandom), 4'h0};
			wr_reg(IDX_ALM1_CNT, 16'(n1));
			wr_reg(IDX_ALM2_CNT, 16'(n2));
			wr_reg(IDX_ALM1_THR, t1);
			wr_reg(IDX_ALM2_THR, t2);
			wr_reg(IDX_ALARM_CONTROL, c);
			if (n1 < 2) n1 = 1;
			if (n2 < 2) n2 = 1;
			for (int k = 0; k < 12; k++) begin
				rnd_src();
				tk();
				h1[k] = val(c[11:8], c[4]);
				h2[k] = val(c[15:12], c[4]);
				av[0] = (k >= n1) && cmp(t1, h1[k] - h1[k-n1]);
				av[1] = (k >= n2) && cmp(t2, h2[k] - h2[k-n2]);
				chk({14'h0000, act}, {14'h0000, av});
			end
		end
		stop_test();
	end
endmodule
